// File: rtl/rcp_pkg.sv
// package of constants for the rom code protection block
package rcp_pkg;
   // ****************************************
   // rom map
   // ****************************************
   localparam int          ROM_AW          = 15;
   localparam int          ROM_DW          = 17;
   localparam logic [14:0] RESERVED_LO     = 15'h7ff8;
   localparam logic [14:0] RESERVED_HI     = 15'h7ffd;
   localparam logic [14:0] PROT_WORD_ADDR  = 15'h7ffe;
   localparam logic [14:0] RESET_VEC_ADDR  = 15'h7fff;
   localparam int          BLOCK_SHIFT     = 9;
   localparam int          PART_W          = 6;
   // ****************************************
   // protection word fields
   // ****************************************
   localparam int          TRUE_MARK_LSB   = 9;
   localparam int          WHOLE_LOCK_BIT  = 8;
   localparam int          BLOCK_LOCK_BIT  = 7;
   localparam int          COMP_MARK_LSB   = 0;
   localparam logic [16:0] PROT_ERASED     = 17'h1ffff;
   // ****************************************
   // ahb register map
   // ****************************************
   localparam logic [7:0]  REG_STATUS      = 8'h00;
   localparam logic [7:0]  REG_PROT_WORD   = 8'h04;
   localparam logic [7:0]  REG_CONTROL     = 8'h08;
   localparam logic [7:0]  REG_BOOT_VEC    = 8'h0c;
   localparam int          CTL_RECHECK     = 0;
   localparam int          CTL_MODE_LSB    = 1;
   localparam int          CTL_VPP_LOW     = 3;
   // ****************************************
   // types
   // ****************************************
   typedef enum logic [1:0] {
      MODE_NORMAL, MODE_EPROM, MODE_EMUL, MODE_TRACE
   } rcp_mode_t;
   typedef enum logic [1:0] {
      PROT_NONE, PROT_BLOCK, PROT_WHOLE
   } rcp_level_t;
endpackage

// File: rtl/rcp_top.sv
// rom code protection logic with ahb-lite register access
//
// The AHB-Lite interface to the registers was left to the implementer.
`timescale 1ns/1ns
// Operation
// - after reset branch via word 0x7fff
// - protection word read from 0x7ffe
// - block scan access and lookup reads
// - lower block and upper block split
// - decode protection word fields
// - partition limit is (n+1)*512
// - programming only clears bits
// - both locks set means no protection
// - block lock protects below partition
// - whole lock clear protects everything
// - power-up check suspends execution
// - recheck before any test mode; trace to emulation with vpp low enters MODE_EMUL at once, with no recheck
// - emulation trace switch needs recheck
// - emulation lookups use external source
// - trace to emulation keeps security
// - partition cannot be moved later
// - 64 partition values over rom
module rcp_top #(
   parameter int ADDR_W = 15
) (
   // clock and reset
   input  wire logic              clock_i,
   input  wire logic              reset_n_i,
   // ahb-lite slave
   input  wire logic              hsel_i,
   input  wire logic [31:0]       haddr_i,
   input  wire logic [1:0]        htrans_i,
   input  wire logic              hwrite_i,
   input  wire logic [2:0]        hsize_i,
   input  wire logic [31:0]       hwdata_i,
   input  wire logic              hready_i,
   output logic      [31:0]       hrdata_o,
   output logic                   hreadyout_o,
   output logic                   hresp_o,
   // rom port shared by init and scan
   output logic      [ADDR_W-1:0] rom_addr_o,
   output logic                   rom_rd_o,
   output logic                   rom_wr_o,
   output logic      [16:0]       rom_wdata_o,
   input  wire logic [16:0]       rom_rdata_i,
   // scan path request
   input  wire logic              scan_req_i,
   input  wire logic              scan_wr_i,
   input  wire logic [ADDR_W-1:0] scan_addr_i,
   input  wire logic [16:0]       scan_wdata_i,
   output logic                   scan_ack_o,
   output logic                   scan_deny_o,
   output logic      [16:0]       scan_rdata_o,
   // lookup check from core
   input  wire logic              lookup_req_i,
   input  wire logic [ADDR_W-1:0] lookup_pc_i,
   input  wire logic [ADDR_W-1:0] lookup_addr_i,
   output logic                   lookup_deny_o,
   output logic                   lookup_ext_o,
   // core control
   output logic                   core_hold_o,
   output logic                   boot_go_o,
   output logic      [16:0]       boot_vec_o,
   output logic      [1:0]        mode_o
);
   // ****************************************
   // reset release
   // ****************************************
   logic rst_s1_q, rst_n;
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_s1_q <= 1'b0;
         rst_n    <= 1'b0;
      end else begin
         rst_s1_q <= 1'b1;
         rst_n    <= rst_s1_q;
      end
   end

   // ****************************************
   // decode functions
   // ****************************************
   function automatic logic [ADDR_W-1:0] part_limit(input logic [5:0] idx);
      part_limit = ADDR_W'({idx, 9'h000}) + ADDR_W'(15'h0200);
   endfunction

   function automatic logic in_low(input logic [ADDR_W-1:0] a, input logic [5:0] idx);
      // lower block test, full 64 range
      in_low = ({1'b0, a} < ({1'b0, part_limit(idx)} | {(idx == 6'h3f), {ADDR_W{1'b0}}}));
   endfunction

   // ****************************************
   // protection state
   // ****************************************
   typedef enum logic [1:0] {ST_RESET, ST_READ, ST_LATCH, ST_RUN} rcp_st_t;
   rcp_st_t st_q, st_d;
   logic [16:0] word_q, vec_q;
   logic        vec_phase_q;
   rcp_pkg::rcp_mode_t mode_q, mode_pend_q;
   logic        recheck_q;

   wire logic [5:0] true_partition_marker       = word_q[rcp_pkg::TRUE_MARK_LSB +: 6];
   wire logic [5:0] complement_partition_marker = word_q[rcp_pkg::COMP_MARK_LSB +: 6];
   wire logic       whole_rom_lock_bit          = word_q[rcp_pkg::WHOLE_LOCK_BIT];
   wire logic       lower_block_lock_bit        = word_q[rcp_pkg::BLOCK_LOCK_BIT];
   wire logic [5:0] partition_index             = true_partition_marker;
   wire logic       marker_ok = (complement_partition_marker == ~partition_index);
   rcp_pkg::rcp_level_t level;
   assign level = !whole_rom_lock_bit ? rcp_pkg::PROT_WHOLE :
                  lower_block_lock_bit ? rcp_pkg::PROT_NONE :
                  marker_ok ? rcp_pkg::PROT_BLOCK : rcp_pkg::PROT_WHOLE;

   function automatic logic prot(input logic [ADDR_W-1:0] a);
      prot = (level == rcp_pkg::PROT_WHOLE) ||
             ((level == rcp_pkg::PROT_BLOCK) && in_low(a, partition_index));
   endfunction

   // ****************************************
   // ahb slave
   // ****************************************
   logic        ph_q, ph_wr_q;
   logic [7:0]  ph_addr_q;
   logic [3:0]  ctl_q;
   wire logic   ahb_go  = hsel_i && htrans_i[1] && hready_i;
   wire logic   ahb_wr  = ph_q && ph_wr_q;
   wire logic   ctl_wr  = ahb_wr && (ph_addr_q == rcp_pkg::REG_CONTROL);
   wire logic [1:0] req_mode = hwdata_i[rcp_pkg::CTL_MODE_LSB +: 2];
   wire logic   vpp_low = hwdata_i[rcp_pkg::CTL_VPP_LOW];
   // trace to emulation by vpp low
   wire logic   vpp_drop = ctl_wr && vpp_low && (mode_q == rcp_pkg::MODE_TRACE) &&
                           (rcp_pkg::rcp_mode_t'(req_mode) == rcp_pkg::MODE_EMUL);
   wire logic   mode_chg = ctl_wr && (rcp_pkg::rcp_mode_t'(req_mode) != mode_q) && !vpp_drop;
   wire logic   sw_chk   = ctl_wr && hwdata_i[rcp_pkg::CTL_RECHECK];
   wire logic [31:0] rd_mux =
      (haddr_i[7:0] == rcp_pkg::REG_STATUS)    ? {26'h0, marker_ok, level, mode_q, (st_q == ST_RUN)} :
      (haddr_i[7:0] == rcp_pkg::REG_PROT_WORD) ? {15'h0, word_q} :
      (haddr_i[7:0] == rcp_pkg::REG_CONTROL)   ? {28'h0, ctl_q} :
      (haddr_i[7:0] == rcp_pkg::REG_BOOT_VEC)  ? {15'h0, vec_q} : 32'h0;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         ph_q      <= 1'b0;
         ph_wr_q   <= 1'b0;
         ph_addr_q <= 8'h00;
         hrdata_o  <= 32'h0;
         ctl_q     <= 4'h0;
      end else begin
         ph_q      <= ahb_go;
         ph_wr_q   <= hwrite_i;
         ph_addr_q <= haddr_i[7:0];
         hrdata_o  <= ahb_go && !hwrite_i ? rd_mux : 32'h0;
         if (ctl_wr)
            ctl_q <= {vpp_low, req_mode, 1'b0};
      end
   end
   assign hreadyout_o = 1'b1;
   assign hresp_o     = 1'b0;

   // ****************************************
   // init sequencer
   // ****************************************
   wire logic chk_req = mode_chg || sw_chk || recheck_q;
   always_comb begin
      st_d = st_q;
      unique case (st_q)
         ST_RESET: st_d = ST_READ;
         ST_READ:  st_d = ST_LATCH;
         ST_LATCH: st_d = vec_phase_q ? ST_RUN : ST_READ;
         ST_RUN:   st_d = chk_req ? ST_READ : ST_RUN;
      endcase
   end

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         st_q        <= ST_RESET;
         word_q      <= rcp_pkg::PROT_ERASED;
         vec_q       <= 17'h0;
         vec_phase_q <= 1'b0;
         mode_q      <= rcp_pkg::MODE_NORMAL;
         mode_pend_q <= rcp_pkg::MODE_NORMAL;
         recheck_q   <= 1'b0;
         boot_go_o   <= 1'b0;
      end else begin
         st_q      <= st_d;
         boot_go_o <= 1'b0;
         if (vpp_drop)
            mode_q <= rcp_pkg::MODE_EMUL;
         if (mode_chg)
            mode_pend_q <= rcp_pkg::rcp_mode_t'(req_mode);
         recheck_q <= (st_q != ST_RUN) && (mode_chg || sw_chk);
         if (st_q == ST_RUN && chk_req)
            vec_phase_q <= 1'b0;
         if (st_q == ST_LATCH) begin
            if (!vec_phase_q) begin
               word_q      <= rom_rdata_i;
               vec_phase_q <= 1'b1;
            end else begin
               // reset vector fetched, new mode enters
               vec_q     <= rom_rdata_i;
               mode_q    <= mode_pend_q;
               boot_go_o <= 1'b1;
            end
         end
      end
   end

   // ****************************************
   // rom port, scan and lookup
   // ****************************************
   wire logic init_busy = (st_q != ST_RUN);
   wire logic scan_go   = scan_req_i && !init_busy;
   wire logic scan_bad  = prot(scan_addr_i);
   wire logic [ADDR_W-1:0] init_addr = vec_phase_q ? rcp_pkg::RESET_VEC_ADDR : rcp_pkg::PROT_WORD_ADDR;
   wire logic same_blk = (in_low(lookup_pc_i, partition_index) == in_low(lookup_addr_i, partition_index));
   // scan answer waits one cycle for the rom data of its own address
   logic      scan_ack_q, scan_deny_q, scan_rd_q;

   always_ff @(posedge clock_i or negedge rst_n) begin
      if (!rst_n) begin
         rom_addr_o    <= '0;
         rom_rd_o      <= 1'b0;
         rom_wr_o      <= 1'b0;
         rom_wdata_o   <= 17'h0;
         scan_ack_o    <= 1'b0;
         scan_deny_o   <= 1'b0;
         scan_rdata_o  <= 17'h0;
         scan_ack_q    <= 1'b0;
         scan_deny_q   <= 1'b0;
         scan_rd_q     <= 1'b0;
         lookup_deny_o <= 1'b0;
         lookup_ext_o  <= 1'b0;
         core_hold_o   <= 1'b1;
      end else begin
         rom_addr_o   <= init_busy ? init_addr : scan_addr_i;
         rom_rd_o     <= init_busy ? (st_d == ST_READ || st_q == ST_READ) : scan_go && !scan_wr_i && !scan_bad;
         rom_wr_o     <= scan_go && scan_wr_i && !scan_bad;
         rom_wdata_o  <= scan_wdata_i;
         scan_ack_q   <= scan_go;
         scan_deny_q  <= scan_go && scan_bad;
         scan_rd_q    <= scan_go && !scan_wr_i && !scan_bad;
         scan_ack_o   <= scan_ack_q && !init_busy;
         scan_deny_o  <= scan_deny_q && !init_busy;
         scan_rdata_o <= scan_rd_q ? rom_rdata_i : 17'h0;
         lookup_deny_o <= lookup_req_i && (init_busy || (prot(lookup_addr_i) && !same_blk));
         lookup_ext_o  <= lookup_req_i && (mode_q == rcp_pkg::MODE_EMUL);
         core_hold_o   <= init_busy;
      end
   end
   assign boot_vec_o = vec_q;
   assign mode_o     = mode_q;
endmodule // rcp_top

// File: bench/rcp_top_props.sv
// checker of the rom protection block ports
`timescale 1ns/1ns
module rcp_top_props #(
   parameter int ADDR_W = 15
) (
   // watched ports
   input wire logic              clock_i,
   input wire logic              reset_n_i,
   input wire logic [ADDR_W-1:0] rom_addr_o,
   input wire logic              rom_rd_o,
   input wire logic              rom_wr_o,
   input wire logic [16:0]       rom_rdata_i,
   input wire logic              scan_req_i,
   input wire logic              scan_ack_o,
   input wire logic              scan_deny_o,
   input wire logic              core_hold_o,
   input wire logic              boot_go_o,
   input wire logic [16:0]       boot_vec_o
);
   logic        seen_q;
   logic [16:0] pw_q;
   logic [16:0] vec_q;
   wire         rd_word = rom_rd_o && rom_addr_o == rcp_pkg::PROT_WORD_ADDR;
   wire         rd_vec  = rom_rd_o && rom_addr_o == rcp_pkg::RESET_VEC_ADDR;
   // **********
   // shadow of words read by init
   // **********
   always_ff @(posedge clock_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         seen_q <= 1'b0;
         pw_q   <= rcp_pkg::PROT_ERASED;
         vec_q  <= 17'h0;
      end else begin
         seen_q <= !boot_go_o && (seen_q || rd_word);
         if (rd_word) pw_q <= rom_rdata_i;
         if (rd_vec) vec_q <= rom_rdata_i;
      end
   end
   // **********
   // properties
   // **********
   default clocking cb @(posedge clock_i); endclocking
   default disable iff (!reset_n_i);
   a_hold_blocks_scan: assert property (core_hold_o |-> !scan_ack_o)
      else $error("scan answered during init");
   a_boot_ends_hold: assert property (boot_go_o |-> ##[0:2] !core_hold_o)
      else $error("hold stays after boot");
   a_init_reads_word: assert property (boot_go_o |-> seen_q)
      else $error("boot without reading the word");
   a_boot_vector: assert property (boot_go_o |-> boot_vec_o == vec_q)
      else $error("boot vector differs from rom");
   a_deny_no_write: assert property (scan_deny_o |-> !rom_wr_o)
      else $error("denied scan wrote the rom");
   a_scan_answer: assert property (scan_req_i && !core_hold_o |-> ##[1:3] (scan_ack_o || scan_deny_o))
      else $error("scan not answered");
   a_whole_lock: assert property (scan_ack_o && !scan_deny_o |-> pw_q[8])
      else $error("access under whole lock");
   a_open_rom: assert property (scan_deny_o |-> !(pw_q[8] && pw_q[7]))
      else $error("deny with both locks set");
endmodule // rcp_top_props
bind rcp_top rcp_top_props #(.ADDR_W(ADDR_W)) u_props (
   .clock_i(clock_i), .reset_n_i(reset_n_i), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
   .rom_wr_o(rom_wr_o), .rom_rdata_i(rom_rdata_i), .scan_req_i(scan_req_i), .scan_ack_o(scan_ack_o),
   .scan_deny_o(scan_deny_o), .core_hold_o(core_hold_o), .boot_go_o(boot_go_o), .boot_vec_o(boot_vec_o)
);

// File: bench/rcp_top_test.sv
// self-checking bench for the rom code protection block
`timescale 1ns/1ns
module rcp_top_test;
   logic        clock_i, reset_n_i, hsel_i, hwrite_i, hready_i, hreadyout_o, hresp_o;
   logic        scan_req_i, scan_wr_i, scan_ack_o, scan_deny_o, scan_done, rom_rd_o, rom_wr_o;
   logic        lookup_req_i, lookup_deny_o, lookup_ext_o, core_hold_o, boot_go_o;
   logic [1:0]  htrans_i, mode_o;
   logic [2:0]  hsize_i;
   logic [5:0]  nn;
   logic [14:0] rom_addr_o, scan_addr_i, lookup_pc_i, lookup_addr_i;
   logic [16:0] rom_wdata_o, rom_rdata_i, scan_wdata_i, scan_rdata_o, boot_vec_o, prot_w;
   logic [31:0] haddr_i, hwdata_i, hrdata_o, rd;
   int          err_total, checks_done;
   localparam logic [16:0] VEC = 17'h0a5c3;
   assign hready_i  = hreadyout_o;
   assign scan_done = scan_ack_o | scan_deny_o;
   // reserved vector words never used as data
   // rom gives the word, the vector, else its own address
   assign rom_rdata_i = rom_addr_o == rcp_pkg::PROT_WORD_ADDR ? prot_w :
                        rom_addr_o == rcp_pkg::RESET_VEC_ADDR ? VEC : {2'h0, rom_addr_o};
   rcp_top dut (
      .clock_i(clock_i), .reset_n_i(reset_n_i), .hsel_i(hsel_i), .haddr_i(haddr_i), .htrans_i(htrans_i),
      .hwrite_i(hwrite_i), .hsize_i(hsize_i), .hwdata_i(hwdata_i), .hready_i(hready_i), .hrdata_o(hrdata_o),
      .hreadyout_o(hreadyout_o), .hresp_o(hresp_o), .rom_addr_o(rom_addr_o), .rom_rd_o(rom_rd_o),
      .rom_wr_o(rom_wr_o), .rom_wdata_o(rom_wdata_o), .rom_rdata_i(rom_rdata_i), .scan_req_i(scan_req_i),
      .scan_wr_i(scan_wr_i), .scan_addr_i(scan_addr_i), .scan_wdata_i(scan_wdata_i), .scan_ack_o(scan_ack_o),
      .scan_deny_o(scan_deny_o), .scan_rdata_o(scan_rdata_o), .lookup_req_i(lookup_req_i),
      .lookup_pc_i(lookup_pc_i), .lookup_addr_i(lookup_addr_i), .lookup_deny_o(lookup_deny_o),
      .lookup_ext_o(lookup_ext_o), .core_hold_o(core_hold_o), .boot_go_o(boot_go_o),
      .boot_vec_o(boot_vec_o), .mode_o(mode_o)
   );
   initial begin
      clock_i = 1'b0;
      forever #20 clock_i = ~clock_i;
   end
   // **********
   // shared tasks
   // **********
   task automatic print_verdict;
      $display("errors %0d checks %0d", err_total, checks_done);
      if (err_total == 0 && checks_done > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         err_total++;
         $display("BAD %0t %s", $time, m);
      end
   endtask
   task automatic wait_hi(input int sel);
      int n;
      n = 0;
      do begin
         @(posedge clock_i);
         n++;
      end while ((sel == 0 ? hreadyout_o : sel == 1 ? scan_done : boot_go_o) !== 1'b1 && n < 200);
      if (n >= 200) begin
         err_total++;
         print_verdict();
      end
   endtask
   task automatic ahb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
      hsel_i <= 1'b1;
      htrans_i <= 2'h2;
      haddr_i <= {24'h0, a};
      hwrite_i <= wr;
      wait_hi(0);
      htrans_i <= 2'h0;
      hwdata_i <= wd;
      wait_hi(0);
      rd = hrdata_o;
      hsel_i <= 1'b0;
   endtask
   task automatic recheck(input logic [16:0] w, input logic [31:0] ctl);
      prot_w <= w;
      ahb(1'b1, rcp_pkg::REG_CONTROL, ctl);
      wait_hi(2);
   endtask
   task automatic scan(input logic w, input logic [14:0] a, input logic dn);
      scan_req_i <= 1'b1;
      scan_wr_i <= w;
      scan_addr_i <= a;
      @(posedge clock_i);
      scan_req_i <= 1'b0;
      wait_hi(1);
      chk(scan_deny_o === dn, "scan deny");
      if (!dn && !w) chk(scan_rdata_o === {2'h0, a}, "scan data");
      @(posedge clock_i);
   endtask
   task automatic look(input logic [14:0] pc, input logic [14:0] a, input logic dn, input logic ex);
      lookup_req_i <= 1'b1;
      lookup_pc_i <= pc;
      lookup_addr_i <= a;
      @(posedge clock_i);
      lookup_req_i <= 1'b0;
      @(posedge clock_i);
      chk(lookup_deny_o === dn && lookup_ext_o === ex, "lookup");
   endtask
   // block lock bit clear, whole lock and reserved bits at one
   function automatic logic [16:0] bw(input logic [5:0] n, input logic [5:0] c);
      return {2'h3, n, 1'b1, 1'b0, 1'b1, c};
   endfunction
   // **********
   // scenarios
   // **********
   initial begin
      {reset_n_i, hsel_i, hwrite_i, scan_req_i, scan_wr_i, lookup_req_i, htrans_i} = '0;
      {haddr_i, hwdata_i, scan_addr_i, lookup_pc_i, lookup_addr_i} = '0;
      hsize_i = 3'h2;
      scan_wdata_i = 17'h0;
      err_total = 0;
      checks_done = 0;
      prot_w = rcp_pkg::PROT_ERASED;
      repeat (4) @(posedge clock_i);
      chk(core_hold_o === 1'b1, "hold in reset");
      reset_n_i <= 1'b1;
      wait_hi(2);
      chk(boot_vec_o === VEC, "boot vector");
      scan(1'b0, 15'h7f00, 1'b0);
      for (int i = 0; i < 2; i++) begin
         nn = i ? 6'd62 : 6'd0;
         recheck(bw(nn, ~nn), 32'h1);
         ahb(1'b0, rcp_pkg::REG_PROT_WORD, 32'h0);
         chk(rd[16:0] === bw(nn, ~nn), "word");
         scan(1'b0, {nn, 9'h1ff}, 1'b1);
         scan(1'b0, {nn + 6'd1, 9'h000}, 1'b0);
      end
      scan(1'b1, 15'h0000, 1'b1);
      look(15'h7e00, 15'h0100, 1'b1, 1'b0);
      look(15'h0100, 15'h0200, 1'b0, 1'b0);
      ahb(1'b0, 8'h10, 32'h0);
      chk(rd === 32'h0, "unmapped read");
      recheck(bw(6'd0, ~6'd2), 32'h1);
      scan(1'b0, 15'h7000, 1'b1);
      recheck(17'h1feff, 32'h1);
      scan(1'b0, 15'h7fff, 1'b1);
      recheck(rcp_pkg::PROT_ERASED, 32'h4);
      chk(mode_o === rcp_pkg::MODE_EMUL, "emulation");
      look(15'h0000, 15'h0010, 1'b0, 1'b1);
      recheck(rcp_pkg::PROT_ERASED, 32'h6);
      chk(mode_o === rcp_pkg::MODE_TRACE, "trace");
      ahb(1'b1, rcp_pkg::REG_CONTROL, 32'hc);
      repeat (2) @(posedge clock_i);
      chk(mode_o === rcp_pkg::MODE_EMUL && core_hold_o === 1'b0, "vpp low");
      print_verdict();
   end
endmodule // rcp_top_test
